// ===== design/mtc_top.v
// trigger and reading sequencing controller with ahb-lite registers
`timescale 1ns/100ps
`include "mtc_defines.vh"
module mtc_top (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    input wire trig_key,
    input wire panel_auto_key,
    input wire panel_iface_usb,
    input wire panel_iface_gpib,
    input wire panel_addr_we,
    input wire [4:0] panel_addr,
    input wire diode_cont_sel,
    input wire [7:0] rj_real_temp,
    input wire ext_trig_n,
    input wire meas_done,
    output reg meas_start,
    output reg measurement_done_output_n,
    output reg trig_ready,
    output reg ext_ind,
    output reg usb_en,
    output reg gpib_en,
    output reg [4:0] gpib_addr,
    output reg reference_junction_source,
    output reg [7:0] rj_temp
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_MEAS = 2'h2;
    reg [1:0] state;
    reg [1:0] mode;
    reg [1:0] src;
    reg [10:0] count;
    reg delay_auto;
    reg [11:0] delay_s;
    reg [7:0] rj_sim;
    reg [10:0] left;
    reg ext_s1, ext_s2, ext_s3;
    reg key_d;
    reg bus_trig;
    reg [2:0] done_cnt;
    reg dp_wr;
    reg [11:0] dp_addr;
    wire ext_fall;
    wire key_rise;
    wire event_in;
    wire fire;
    reg [31:0] next_rdata;

    assign ext_fall = ext_s3 & ~ext_s2;
    assign key_rise = trig_key & ~key_d;
    // pick event by source: imm always, ext edge, bus command, or panel key in single mode (panel otherwise always)
    assign event_in = (src == `MTC_SRC_EXT) ? ext_fall :
                      (src == `MTC_SRC_BUS) ? bus_trig :
                      (src == `MTC_SRC_IMM) ? 1'b1 :
                      (mode == `MTC_MODE_SINGLE) ? key_rise :
                      1'b1;
    assign fire = (state == ST_WAIT) & event_in;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_s1 <= 1'b1;
            ext_s2 <= 1'b1;
            ext_s3 <= 1'b1;
            key_d <= 1'b0;
        end else begin
            ext_s1 <= ext_trig_n;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            key_d <= trig_key;
        end
    end

    // ahb-lite slave, zero wait states
    always @* begin
        next_rdata = 32'h00000000;
        case (haddr)
            `MTC_OFS_CTRL: next_rdata = {30'h0, mode};
            `MTC_OFS_SRC: next_rdata = {30'h0, src};
            `MTC_OFS_COUNT: next_rdata = {21'h0, count};
            `MTC_OFS_DELAY: next_rdata = {19'h0, delay_auto, delay_s};
            `MTC_OFS_RJ: next_rdata = {15'h0, reference_junction_source, rj_real_temp, rj_sim};
            `MTC_OFS_IFACE: next_rdata = {25'h0, gpib_en, usb_en, gpib_addr};
            `MTC_OFS_STATUS: next_rdata = {27'h0, diode_cont_sel, ext_ind, trig_ready, state};
            default: next_rdata = 32'h00000000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            dp_wr <= 1'b0;
            dp_addr <= 12'h000;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            dp_wr <= hsel & hready & htrans[1] & hwrite;
            if (hsel & hready & htrans[1]) begin
                dp_addr <= haddr;
            end
            if (hsel & hready & htrans[1] & ~hwrite) begin
                hrdata <= next_rdata;
            end
        end
    end

    // configuration registers, volatile
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode <= `MTC_MODE_AUTO;
            src <= `MTC_SRC_PANEL;
            count <= `MTC_COUNT_RST;
            delay_auto <= 1'b1;
            delay_s <= 12'h000;
            rj_sim <= `MTC_RJ_SIM_RST;
            reference_junction_source <= 1'b0;
            bus_trig <= 1'b0;
            usb_en <= 1'b1;
            gpib_en <= 1'b0;
            gpib_addr <= `MTC_GPIB_RST;
        end else begin
            bus_trig <= 1'b0;
            if (panel_auto_key) begin
                mode <= `MTC_MODE_AUTO;
                src <= `MTC_SRC_PANEL;
            end else if (key_rise && src == `MTC_SRC_PANEL && !diode_cont_sel) begin
                mode <= `MTC_MODE_SINGLE;
            end
            if (dp_wr) begin
                case (dp_addr)
                    `MTC_OFS_CTRL: begin
                        if (hwdata[1:0] == `MTC_MODE_AUTO || hwdata[1:0] == `MTC_MODE_IMM) begin
                            mode <= hwdata[1:0];
                        end else if (hwdata[1:0] == `MTC_MODE_SINGLE && !diode_cont_sel) begin
                            mode <= hwdata[1:0];
                        end
                    end
                    `MTC_OFS_SRC: begin
                        src <= hwdata[1:0];
                        if (hwdata[1:0] != `MTC_SRC_PANEL) begin
                            mode <= `MTC_MODE_IMM;
                        end
                    end
                    `MTC_OFS_COUNT: begin
                        if (hwdata[10:0] != 11'h000 && hwdata[31:11] == 21'h0 && hwdata[10:0] <= `MTC_COUNT_MAX) begin
                            count <= hwdata[10:0];
                        end
                    end
                    `MTC_OFS_DELAY: begin
                        delay_auto <= hwdata[12];
                        if (hwdata[11:0] <= `MTC_DELAY_MAX) begin
                            delay_s <= hwdata[11:0];
                        end
                    end
                    `MTC_OFS_RJ: begin
                        rj_sim <= hwdata[7:0];
                        reference_junction_source <= hwdata[16];
                    end
                    `MTC_OFS_CMD: bus_trig <= hwdata[0];
                    default: bus_trig <= 1'b0;
                endcase
            end
            // interface choice and address from panel only
            if (panel_iface_usb) begin
                usb_en <= 1'b1;
                gpib_en <= 1'b0;
            end else if (panel_iface_gpib) begin
                usb_en <= 1'b0;
                gpib_en <= 1'b1;
            end
            if (panel_addr_we) begin
                gpib_addr <= panel_addr;
            end
        end
    end

    // reading sequencer
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= ST_IDLE;
            left <= 11'h000;
            meas_start <= 1'b0;
            trig_ready <= 1'b0;
            ext_ind <= 1'b0;
            rj_temp <= 8'h00;
            done_cnt <= 3'h0;
            measurement_done_output_n <= 1'b1;
        end else begin
            meas_start <= 1'b0;
            ext_ind <= (src == `MTC_SRC_EXT);
            rj_temp <= reference_junction_source ? rj_sim : rj_real_temp;
            case (state)
                ST_IDLE: begin
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (fire) begin
                        left <= count;
                        meas_start <= 1'b1;
                        state <= ST_MEAS;
                    end
                end
                ST_MEAS: begin
                    if (meas_done) begin
                        if (left > 11'h001) begin
                            left <= left - 11'h001;
                            meas_start <= 1'b1;
                        end else begin
                            left <= 11'h000;
                            state <= ST_WAIT;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
            trig_ready <= (state == ST_WAIT) & ~fire;
            if (state == ST_MEAS && meas_done) begin
                done_cnt <= `MTC_DONE_CYC;
                measurement_done_output_n <= 1'b0;
            end else if (done_cnt > 3'h1) begin
                done_cnt <= done_cnt - 3'h1;
            end else begin
                done_cnt <= 3'h0;
                measurement_done_output_n <= 1'b1;
            end
        end
    end
endmodule

// ===== common/mtc_defines.vh
// constants for the meter trigger controller
`ifndef MTC_DEFINES_VH
`define MTC_DEFINES_VH
`define MTC_OFS_CTRL 12'h000
`define MTC_OFS_SRC 12'h004
`define MTC_OFS_COUNT 12'h008
`define MTC_OFS_DELAY 12'h00c
`define MTC_OFS_RJ 12'h010
`define MTC_OFS_IFACE 12'h014
`define MTC_OFS_CMD 12'h018
`define MTC_OFS_STATUS 12'h01c
`define MTC_MODE_AUTO 2'h0
`define MTC_MODE_IMM 2'h1
`define MTC_MODE_SINGLE 2'h2
`define MTC_SRC_PANEL 2'h0
`define MTC_SRC_IMM 2'h1
`define MTC_SRC_EXT 2'h2
`define MTC_SRC_BUS 2'h3
`define MTC_COUNT_RST 11'h001
`define MTC_COUNT_MAX 11'h7d0
`define MTC_DELAY_MAX 12'he10
`define MTC_GPIB_RST 5'h16
`define MTC_RJ_SIM_RST 8'h19
`define MTC_DONE_NS 100
`define MTC_CLK_NS 25
`define MTC_DONE_CYC 3'h4
`endif

// ===== testbench/mtc_chk.sv
// port assertions for the trigger controller
`timescale 1ns/100ps
module mtc_chk (
    input wire hclk,
    input wire hresetn,
    input wire meas_done,
    input wire meas_start,
    input wire measurement_done_output_n,
    input wire trig_ready,
    input wire usb_en,
    input wire gpib_en,
    input wire panel_iface_usb,
    input wire panel_iface_gpib,
    input wire panel_addr_we,
    input wire [4:0] panel_addr,
    input wire [4:0] gpib_addr,
    input wire reference_junction_source,
    input wire [7:0] rj_real_temp,
    input wire [7:0] rj_temp
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_low4;
        !measurement_done_output_n [*4] ##1 measurement_done_output_n;
    endsequence
    sequence s_no_panel;
        (!panel_iface_usb && !panel_iface_gpib) [*2];
    endsequence
    a_done_width: assert property ($fell(measurement_done_output_n) |-> s_low4) else $error("done width");
    a_done_cause: assert property (meas_done |-> ##[1:2] !measurement_done_output_n) else $error("no done");
    a_ready_start: assert property (meas_start |-> !trig_ready) else $error("ready in run");
    a_start_one: assert property (meas_start |=> !meas_start) else $error("start width");
    a_one_iface: assert property (usb_en != gpib_en) else $error("iface pair");
    a_iface_hold: assert property (s_no_panel |=> $stable(usb_en)) else $error("iface moved");
    a_addr_load: assert property (panel_addr_we |-> ##[1:2] gpib_addr == panel_addr) else $error("addr");
    a_rj_real: assert property (!reference_junction_source [*2] |-> rj_temp == rj_real_temp) else $error("rj");
endmodule
bind mtc_top mtc_chk u_chk (.hclk, .hresetn, .meas_done, .meas_start, .measurement_done_output_n, .trig_ready,
    .usb_en, .gpib_en, .panel_iface_usb, .panel_iface_gpib, .panel_addr_we, .panel_addr, .gpib_addr,
    .reference_junction_source, .rj_real_temp, .rj_temp);

// ===== testbench/mtc_meas_model.sv
// measurement engine: one done pulse lat cycles after each start
`timescale 1ns/100ps
module mtc_meas_model (
    input wire hclk,
    input wire hresetn,
    input wire meas_start,
    input wire [3:0] lat,
    output logic meas_done
);
    logic [3:0] cnt;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 4'h0;
            meas_done <= 1'h0;
        end else begin
            meas_done <= cnt == 4'h1;
            cnt <= meas_start ? lat : cnt - {3'h0, cnt != 4'h0};
        end
    end
endmodule

// ===== testbench/meter_trigger_control_tb_top.sv
// self-checking bench for the trigger controller
`timescale 1ns/100ps
`include "mtc_defines.vh"
module meter_trigger_control_tb_top;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, trig_key = 1'h0, panel_auto_key = 1'h0;
    logic panel_iface_usb = 1'h0, panel_iface_gpib = 1'h0, panel_addr_we = 1'h0, diode_cont_sel = 1'h0;
    logic ext_trig_n = 1'h1, rd_dp = 1'h0;
    logic [11:0] haddr = 12'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, seed, q[$];
    logic [4:0] panel_addr = 5'h0;
    logic [7:0] rj_real_temp;
    logic [3:0] lat;
    wire hreadyout, hresp, meas_start, meas_done, measurement_done_output_n, trig_ready, ext_ind, usb_en, gpib_en;
    wire reference_junction_source;
    wire [31:0] hrdata;
    wire [4:0] gpib_addr;
    wire [7:0] rj_temp;
    int miscompares = 0, n_checks = 0, ns = 0, n;
    mtc_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .trig_key, .panel_auto_key, .panel_iface_usb, .panel_iface_gpib,
        .panel_addr_we, .panel_addr, .diode_cont_sel, .rj_real_temp, .ext_trig_n, .meas_done, .meas_start,
        .measurement_done_output_n, .trig_ready, .ext_ind, .usb_en, .gpib_en, .gpib_addr,
        .reference_junction_source, .rj_temp);
    mtc_meas_model u_meas (.hclk, .hresetn, .meas_start, .lat, .meas_done);
    function logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task chk(input logic [31:0] v, input logic [31:0] e);
        n_checks++;
        if (v !== e) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, v, e);
        end
    endtask
    task stop_test;
        if (miscompares == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task cyc(input int c);
        repeat (c) @(posedge hclk);
    endtask
    task wt;
        int i;
        for (i = 0; i < 400 && hreadyout !== 1'h1; i++)
            @(posedge hclk);
        if (i == 400) begin
            miscompares++;
            stop_test;
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        if (!w)
            q.push_back(d);
        hsel <= 1'h1;
        hwrite <= w;
        haddr <= a;
        htrans <= 2'h2;
        @(posedge hclk);
        wt();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        wt();
    endtask
    task rdy;
        int i;
        for (i = 0; i < 400 && trig_ready !== 1'h1; i++)
            @(posedge hclk);
        if (i == 400) begin
            miscompares++;
            stop_test;
        end
    endtask
    task key;
        trig_key <= 1'h1;
        cyc(4);
        trig_key <= 1'h0;
        cyc(4);
    endtask
    task dflt;
        bus(0, `MTC_OFS_CTRL, 32'h0);
        bus(0, `MTC_OFS_SRC, 32'h0);
        bus(0, `MTC_OFS_COUNT, 32'h1);
        bus(0, `MTC_OFS_DELAY, 32'h1000);
        bus(0, `MTC_OFS_RJ, {16'h0, rj_real_temp, 8'h19});
        bus(0, `MTC_OFS_IFACE, 32'h36);
        n = ns;
        cyc(60);
        chk(32'(ns - n > 2), 32'h1);
    endtask
    always @(posedge hclk) begin
        if (meas_start === 1'h1)
            ns++;
        if (rd_dp && hreadyout)
            chk(hrdata, q.pop_front());
        if (hreadyout)
            rd_dp <= hsel && htrans[1] && !hwrite;
    end
    initial forever #12.5 hclk = ~hclk;
    initial begin
        #2000000;
        miscompares++;
        stop_test;
    end
    initial begin
        seed = xs(32'h6788);
        rj_real_temp = seed[7:0];
        lat = 4'h6 + {1'h0, seed[10:8]};
        cyc(2);
        hresetn <= 1'h1;
        dflt();
        bus(1, `MTC_OFS_SRC, 32'h3);
        bus(0, `MTC_OFS_CTRL, 32'h1);
        rdy();
        bus(1, `MTC_OFS_COUNT, 32'h7d1);
        bus(1, `MTC_OFS_COUNT, 32'h0);
        bus(0, `MTC_OFS_COUNT, 32'h1);
        bus(1, `MTC_OFS_COUNT, 32'h7d0);
        bus(0, `MTC_OFS_COUNT, 32'h7d0);
        bus(1, `MTC_OFS_COUNT, 32'h3);
        bus(1, `MTC_OFS_DELAY, 32'he11);
        bus(0, `MTC_OFS_DELAY, 32'h0);
        bus(1, `MTC_OFS_DELAY, 32'he10);
        bus(0, `MTC_OFS_DELAY, 32'he10);
        n = ns;
        bus(1, `MTC_OFS_CMD, 32'h1);
        cyc(80);
        rdy();
        chk(32'(ns - n), 32'h3);
        bus(1, `MTC_OFS_SRC, 32'h2);
        rdy();
        cyc(2);
        chk(ext_ind, 1'h1);
        n = ns;
        ext_trig_n <= 1'h0;
        cyc(12);
        ext_trig_n <= 1'h1;
        cyc(2);
        ext_trig_n <= 1'h0;
        cyc(3);
        ext_trig_n <= 1'h1;
        cyc(80);
        rdy();
        chk(32'(ns - n), 32'h3);
        bus(1, `MTC_OFS_SRC, 32'h1);
        n = ns;
        cyc(60);
        chk(32'(ns - n > 2), 32'h1);
        panel_auto_key <= 1'h1;
        cyc(1);
        panel_auto_key <= 1'h0;
        diode_cont_sel <= 1'h1;
        key();
        chk(ext_ind, 1'h0);
        bus(1, `MTC_OFS_CTRL, 32'h2);
        bus(0, `MTC_OFS_CTRL, 32'h0);
        diode_cont_sel <= 1'h0;
        key();
        bus(0, `MTC_OFS_CTRL, 32'h2);
        rdy();
        n = ns;
        key();
        cyc(80);
        rdy();
        chk(32'(ns - n), 32'h3);
        panel_iface_gpib <= 1'h1;
        cyc(1);
        panel_iface_gpib <= 1'h0;
        bus(1, `MTC_OFS_IFACE, 32'h0);
        bus(0, `MTC_OFS_IFACE, 32'h56);
        panel_addr <= 5'h1f;
        panel_addr_we <= 1'h1;
        cyc(1);
        panel_addr_we <= 1'h0;
        cyc(2);
        chk(gpib_addr, 5'h1f);
        bus(1, `MTC_OFS_RJ, 32'h1ff17);
        bus(0, `MTC_OFS_RJ, {15'h0, 1'h1, rj_real_temp, 8'h17});
        chk(rj_temp, 8'h17);
        bus(0, 12'h100, 32'h0);
        hresetn <= 1'h0;
        cyc(2);
        hresetn <= 1'h1;
        dflt();
        stop_test();
    end
endmodule
